// ### core/tx_frame_security_control.sv
// Transmit-side security control: registers, key store, launch and result logging
//
// Summary of operation
// RL1: Frames from transmit buffers are AES-128 encrypted using the stored 128-bit key.
// RL2: Suite code decodes to none, CTR, CCM 128/64/32, CBC-MAC 128/64/32.
// RL3: Key memory holds four 16-byte keys; top one serves receive decryption.
// RL4: Normal key at 0x280-0x28F, slot 1 at 0x290-0x29F, slot 2 at 0x2A0-0x2AF.
// RL5: Beacon buffer uses the slot 2 key storage.
// RL6: Suite fields: 0x2C[2:0] normal, 0x37[2:0]/[5:3] slots, 0x2D[6:4] beacon.
// RL7: Each buffer control register has security enable bit 1, trigger bit 0.
// RL8: Host loads frame, key, suite, then sets enable and trigger.
// RL9: Enable plus trigger set makes the engine encrypt and send the frame.
// RL10: Normal done raises flag 0x31[0]; 0x24[0] is 1 on failure.
// RL11: Normal retry count lands in 0x24[7:6].
// RL12: 0x24[5] marks a failure caused by a busy channel.
// RL13: Slot done raises 0x31[1] or [2]; 0x24[1]/[2] is 1 on success.
// RL14: Slot retry count lands in bits 7:6 of its control register.
// RL15: 0x24[3] or [4] marks slot failure for lack of slot time.
// RL16: Trigger without enable sends the frame unencrypted.
`timescale 1ns/1ps
`default_nettype none
module tx_frame_security_control (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [9:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWrData,
    input wire logic regRead,
    output logic [7:0] regRdData,
    input wire logic engineDone,
    input wire logic engineOk,
    input wire logic [1:0] engineRetries,
    input wire logic engineChanBusy,
    input wire logic engineNoTime,
    input wire logic [3:0] keyByteIdx,
    output logic txStart,
    output tx_sec_pkg::buffer_t txBuffer,
    output tx_sec_pkg::suite_t txSuite,
    output logic txEncrypt,
    output logic [4:0] txTagBytes,
    output logic [1:0] txKeySlot,
    output logic [7:0] keyByte
);
    import tx_sec_pkg::*;

    // ======================================================
    // Register state
    logic [3:0] trigReg;
    logic [3:0] secEnReg;
    logic [2:0] normalSuiteReg;
    logic [2:0] slot1SuiteReg;
    logic [2:0] slot2SuiteReg;
    logic [2:0] beaconSuiteReg;
    logic [3:0] slot1MiscReg;
    logic [3:0] slot2MiscReg;
    logic [1:0] slot1RetryReg;
    logic [1:0] slot2RetryReg;
    logic [7:0] txResultReg;
    logic [2:0] intFlagsReg;
    logic [7:0] intEnablesReg;
    txState_t stateReg;

    logic [3:0] trigNext;
    logic [3:0] trigWrite;
    logic [3:0] launchClear;
    logic [2:0] flagSet;
    logic [2:0] flagsNext;
    logic launch;
    buffer_t pickBuf;
    logic [2:0] pickSuite;
    logic doneNow;

    // ======================================================
    // Write decode
    always_comb begin
        trigWrite = 4'h0;
        if (regWrite && regWrData[TRIG_BIT]) begin
            trigWrite[BUF_NORMAL] = (regAddr == NORMAL_CTRL_ADDR); // RL7
            trigWrite[BUF_SLOT1] = (regAddr == SLOT1_CTRL_ADDR); // RL7
            trigWrite[BUF_SLOT2] = (regAddr == SLOT2_CTRL_ADDR); // RL7
            trigWrite[BUF_BEACON] = (regAddr == BEACON_CTRL_ADDR); // RL7
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            secEnReg <= 4'h0;
            slot1MiscReg <= 4'h0;
            slot2MiscReg <= 4'h0;
            intEnablesReg <= REG_RESET;
        end else if (regWrite) begin
            case (regAddr)
                NORMAL_CTRL_ADDR: secEnReg[BUF_NORMAL] <= regWrData[SECEN_BIT]; // RL7
                BEACON_CTRL_ADDR: secEnReg[BUF_BEACON] <= regWrData[SECEN_BIT]; // RL7
                SLOT1_CTRL_ADDR: begin
                    secEnReg[BUF_SLOT1] <= regWrData[SECEN_BIT]; // RL7
                    slot1MiscReg <= regWrData[SLOT_MISC_LSB +: 4];
                end
                SLOT2_CTRL_ADDR: begin
                    secEnReg[BUF_SLOT2] <= regWrData[SECEN_BIT]; // RL7
                    slot2MiscReg <= regWrData[SLOT_MISC_LSB +: 4];
                end
                INT_ENABLES_ADDR: intEnablesReg <= regWrData;
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            normalSuiteReg <= SUITE_RESET;
            slot1SuiteReg <= SUITE_RESET;
            slot2SuiteReg <= SUITE_RESET;
            beaconSuiteReg <= SUITE_RESET;
        end else if (regWrite) begin
            case (regAddr)
                SEC_CTRL_A_ADDR: normalSuiteReg <= regWrData[NORMAL_SUITE_LSB +: 3]; // RL6
                SEC_CTRL_B_ADDR: beaconSuiteReg <= regWrData[BEACON_SUITE_LSB +: 3]; // RL6
                SEC_CTRL_C_ADDR: begin
                    slot1SuiteReg <= regWrData[SLOT1_SUITE_LSB +: 3]; // RL6
                    slot2SuiteReg <= regWrData[SLOT2_SUITE_LSB +: 3]; // RL6
                end
                default: ;
            endcase
        end
    end

    // ======================================================
    // Trigger handling; a fresh write wins over the launch clear
    assign trigNext = (trigReg & ~launchClear) | trigWrite;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            trigReg <= 4'h0;
        end else begin
            trigReg <= trigNext;
        end
    end

    // ======================================================
    // Launch: beacon first, then slots, then normal traffic
    always_comb begin
        pickBuf = BUF_NORMAL;
        pickSuite = normalSuiteReg;
        if (trigReg[BUF_BEACON]) begin
            pickBuf = BUF_BEACON;
            pickSuite = beaconSuiteReg;
        end else if (trigReg[BUF_SLOT1]) begin
            pickBuf = BUF_SLOT1;
            pickSuite = slot1SuiteReg;
        end else if (trigReg[BUF_SLOT2]) begin
            pickBuf = BUF_SLOT2;
            pickSuite = slot2SuiteReg;
        end
    end

    assign launch = (stateReg == ST_IDLE) && (trigReg != 4'h0); // RL9
    assign doneNow = (stateReg == ST_BUSY) && engineDone;

    always_comb begin
        launchClear = 4'h0;
        if (launch) begin
            launchClear[pickBuf] = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            stateReg <= ST_IDLE;
        end else begin
            case (stateReg)
                ST_IDLE: if (launch) stateReg <= ST_BUSY;
                ST_BUSY: if (engineDone) stateReg <= ST_IDLE;
                default: stateReg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            txStart <= 1'b0;
            txBuffer <= BUF_NORMAL;
            txSuite <= SUITE_NONE;
            txEncrypt <= 1'b0;
            txTagBytes <= TAG_NONE;
            txKeySlot <= KEY_SLOT_NORMAL;
        end else begin
            txStart <= launch; // RL9
            if (launch) begin
                txBuffer <= pickBuf;
                // Security off sends the frame in clear
                txEncrypt <= secEnReg[pickBuf]; // RL16
                txSuite <= secEnReg[pickBuf] ? suite_t'(pickSuite) : SUITE_NONE; // RL16
                case (secEnReg[pickBuf] ? pickSuite : SUITE_NONE)
                    SUITE_CCM128, SUITE_MAC128: txTagBytes <= TAG_128; // RL2
                    SUITE_CCM64, SUITE_MAC64: txTagBytes <= TAG_64; // RL2
                    SUITE_CCM32, SUITE_MAC32: txTagBytes <= TAG_32; // RL2
                    default: txTagBytes <= TAG_NONE; // RL2
                endcase
                case (pickBuf)
                    BUF_SLOT1: txKeySlot <= KEY_SLOT_SLOT1; // RL4
                    BUF_SLOT2, BUF_BEACON: txKeySlot <= KEY_SLOT_SLOT2; // RL5
                    default: txKeySlot <= KEY_SLOT_NORMAL; // RL4
                endcase
            end
        end
    end

    // ======================================================
    // Result logging
    always_ff @(posedge core_clk) begin
        if (reset) begin
            txResultReg <= REG_RESET;
            slot1RetryReg <= 2'h0;
            slot2RetryReg <= 2'h0;
        end else if (doneNow && txBuffer != BUF_BEACON) begin
            txResultReg[CHAN_BUSY_BIT] <= !engineOk && engineChanBusy; // RL12
            case (txBuffer)
                BUF_NORMAL: begin
                    txResultReg[NORMAL_FAIL_BIT] <= !engineOk; // RL10
                    txResultReg[RETRY_LSB +: 2] <= engineRetries; // RL11
                end
                BUF_SLOT1: begin
                    txResultReg[SLOT1_OK_BIT] <= engineOk; // RL13
                    txResultReg[SLOT1_NOTIME_BIT] <= !engineOk && engineNoTime; // RL15
                    slot1RetryReg <= engineRetries; // RL14
                end
                default: begin
                    txResultReg[SLOT2_OK_BIT] <= engineOk; // RL13
                    txResultReg[SLOT2_NOTIME_BIT] <= !engineOk && engineNoTime; // RL15
                    slot2RetryReg <= engineRetries; // RL14
                end
            endcase
        end
    end

    // Flags clear on read; a completion in the same cycle still sets
    always_comb begin
        flagSet = 3'h0;
        if (doneNow) begin
            flagSet[NORMAL_DONE_BIT] = (txBuffer == BUF_NORMAL); // RL10
            flagSet[SLOT1_DONE_BIT] = (txBuffer == BUF_SLOT1); // RL13
            flagSet[SLOT2_DONE_BIT] = (txBuffer == BUF_SLOT2); // RL13
        end
        flagsNext = flagSet | intFlagsReg;
        if (regRead && regAddr == INT_FLAGS_ADDR) begin
            flagsNext = flagSet;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            intFlagsReg <= 3'h0;
        end else begin
            intFlagsReg <= flagsNext;
        end
    end

    // ======================================================
    // Read port; keys are write-only so they never leak back out
    always_ff @(posedge core_clk) begin
        if (reset) begin
            regRdData <= REG_RESET;
        end else if (regRead) begin
            case (regAddr)
                BEACON_CTRL_ADDR: regRdData <= {6'h00, secEnReg[BUF_BEACON], trigReg[BUF_BEACON]};
                NORMAL_CTRL_ADDR: regRdData <= {6'h00, secEnReg[BUF_NORMAL], trigReg[BUF_NORMAL]};
                SLOT1_CTRL_ADDR: regRdData <= {slot1RetryReg, slot1MiscReg,
                    secEnReg[BUF_SLOT1], trigReg[BUF_SLOT1]};
                SLOT2_CTRL_ADDR: regRdData <= {slot2RetryReg, slot2MiscReg,
                    secEnReg[BUF_SLOT2], trigReg[BUF_SLOT2]};
                TX_RESULT_ADDR: regRdData <= txResultReg;
                SEC_CTRL_A_ADDR: regRdData <= {5'h00, normalSuiteReg};
                SEC_CTRL_B_ADDR: regRdData <= {1'b0, beaconSuiteReg, 4'h0};
                SEC_CTRL_C_ADDR: regRdData <= {2'h0, slot2SuiteReg, slot1SuiteReg};
                INT_FLAGS_ADDR: regRdData <= {5'h00, intFlagsReg};
                INT_ENABLES_ADDR: regRdData <= intEnablesReg;
                default: regRdData <= REG_RESET;
            endcase
        end
    end

    // ======================================================
    // Key store: 0x280-0x2BF, four 16-byte keys, engine reads one byte a cycle
    logic keyWrite;
    logic [9:0] keyOffset;
    assign keyWrite = regWrite && regAddr >= KEY_BASE_ADDR && regAddr <= KEY_END_ADDR; // RL3
    assign keyOffset = regAddr - KEY_BASE_ADDR;

    tx_key_memory #(.ADDR_W(6), .DATA_W(8)) keyStore (
        .clk(core_clk),
        .wrEn(keyWrite),
        .wrAddr(keyOffset[5:0]), // RL4
        .wrData(regWrData),
        .rdAddr({txKeySlot, keyByteIdx}), // RL1
        .rdData(keyByte)
    );

    // ======================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    start_pulse_a: assert property (txStart |=> !txStart) // RL9
        else $error("start longer than one cycle");
    launch_follows_a: assert property ((stateReg == ST_IDLE && trigReg != 4'h0) |=> txStart) // RL9
        else $error("pending trigger not launched");
    plain_send_a: assert property (txStart && !txEncrypt |-> txSuite == SUITE_NONE) // RL16
        else $error("clear frame carries a suite");
    beacon_key_a: assert property (txStart && txBuffer == BUF_BEACON
        |-> txKeySlot == KEY_SLOT_SLOT2) // RL5
        else $error("beacon uses wrong key");
    tag_length_a: assert property (txStart && txSuite == SUITE_CCM64 |-> txTagBytes == TAG_64) // RL2
        else $error("wrong tag length");
    normal_flag_a: assert property (doneNow && txBuffer == BUF_NORMAL |=> intFlagsReg[0]) // RL10
        else $error("normal done flag missing");
    normal_sense_a: assert property (doneNow && txBuffer == BUF_NORMAL
        |=> txResultReg[NORMAL_FAIL_BIT] == !$past(engineOk)) // RL10
        else $error("normal status sense wrong");
    normal_retry_a: assert property (doneNow && txBuffer == BUF_NORMAL
        |=> txResultReg[7:6] == $past(engineRetries)) // RL11
        else $error("normal retry not logged");
    chan_busy_a: assert property (doneNow && txBuffer == BUF_NORMAL && !engineOk && engineChanBusy
        |=> txResultReg[CHAN_BUSY_BIT]) // RL12
        else $error("busy channel not logged");
    slot_sense_a: assert property (doneNow && txBuffer == BUF_SLOT1
        |=> txResultReg[SLOT1_OK_BIT] == $past(engineOk) && intFlagsReg[1]) // RL13
        else $error("slot status sense wrong");
    slot_retry_a: assert property (doneNow && txBuffer == BUF_SLOT2
        |=> slot2RetryReg == $past(engineRetries)) // RL14
        else $error("slot retry not logged");
    slot_notime_a: assert property (doneNow && txBuffer == BUF_SLOT2 && !engineOk && engineNoTime
        |=> txResultReg[SLOT2_NOTIME_BIT]) // RL15
        else $error("slot time failure not logged");
endmodule : tx_frame_security_control
`default_nettype wire

// ### core/tx_sec_pkg.sv
// Constants and types shared by the transmit security control logic
package tx_sec_pkg;
    // ======================================================
    // Register long addresses
    localparam logic [9:0] BEACON_CTRL_ADDR = 10'h01a;
    localparam logic [9:0] NORMAL_CTRL_ADDR = 10'h01b;
    localparam logic [9:0] SLOT1_CTRL_ADDR = 10'h01c;
    localparam logic [9:0] SLOT2_CTRL_ADDR = 10'h01d;
    localparam logic [9:0] TX_RESULT_ADDR = 10'h024;
    localparam logic [9:0] SEC_CTRL_A_ADDR = 10'h02c;
    localparam logic [9:0] SEC_CTRL_B_ADDR = 10'h02d;
    localparam logic [9:0] INT_FLAGS_ADDR = 10'h031;
    localparam logic [9:0] INT_ENABLES_ADDR = 10'h032;
    localparam logic [9:0] SEC_CTRL_C_ADDR = 10'h037;
    localparam logic [9:0] KEY_BASE_ADDR = 10'h280;
    localparam logic [9:0] KEY_END_ADDR = 10'h2bf;
    // ======================================================
    // Field positions
    localparam int TRIG_BIT = 0;
    localparam int SECEN_BIT = 1;
    localparam int RETRY_LSB = 6;
    localparam int SLOT_MISC_LSB = 2;
    localparam int NORMAL_FAIL_BIT = 0;
    localparam int SLOT1_OK_BIT = 1;
    localparam int SLOT2_OK_BIT = 2;
    localparam int SLOT1_NOTIME_BIT = 3;
    localparam int SLOT2_NOTIME_BIT = 4;
    localparam int CHAN_BUSY_BIT = 5;
    localparam int NORMAL_SUITE_LSB = 0;
    localparam int SLOT1_SUITE_LSB = 0;
    localparam int SLOT2_SUITE_LSB = 3;
    localparam int BEACON_SUITE_LSB = 4;
    localparam int NORMAL_DONE_BIT = 0;
    localparam int SLOT1_DONE_BIT = 1;
    localparam int SLOT2_DONE_BIT = 2;
    // ======================================================
    // Reset values
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [2:0] SUITE_RESET = 3'h0;
    // ======================================================
    // Key slots, one 16-byte key each
    localparam logic [1:0] KEY_SLOT_NORMAL = 2'h0;
    localparam logic [1:0] KEY_SLOT_SLOT1 = 2'h1;
    localparam logic [1:0] KEY_SLOT_SLOT2 = 2'h2;
    localparam logic [1:0] KEY_SLOT_RX = 2'h3;
    // ======================================================
    // Tag lengths in bytes
    localparam logic [4:0] TAG_NONE = 5'h00;
    localparam logic [4:0] TAG_128 = 5'h10;
    localparam logic [4:0] TAG_64 = 5'h08;
    localparam logic [4:0] TAG_32 = 5'h04;

    typedef enum logic [2:0] {
        SUITE_NONE = 3'h0,
        SUITE_CTR = 3'h1,
        SUITE_CCM128 = 3'h2,
        SUITE_CCM64 = 3'h3,
        SUITE_CCM32 = 3'h4,
        SUITE_MAC128 = 3'h5,
        SUITE_MAC64 = 3'h6,
        SUITE_MAC32 = 3'h7
    } suite_t;

    typedef enum logic [1:0] {
        BUF_NORMAL = 2'h0,
        BUF_SLOT1 = 2'h1,
        BUF_SLOT2 = 2'h2,
        BUF_BEACON = 2'h3
    } buffer_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } txState_t;
endpackage : tx_sec_pkg

// ### core/tx_key_memory.sv
// Key storage with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
module tx_key_memory #(
    parameter int ADDR_W = 6,
    parameter int DATA_W = 8
) (
    input wire logic clk,
    input wire logic wrEn,
    input wire logic [ADDR_W-1:0] wrAddr,
    input wire logic [DATA_W-1:0] wrData,
    input wire logic [ADDR_W-1:0] rdAddr,
    output logic [DATA_W-1:0] rdData
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk) begin
        rdData <= mem[rdAddr];
    end
endmodule : tx_key_memory
`default_nettype wire

// ### verification/tx_engine_model.sv
// Behavioural transmit engine: fetches the launched key and reports one outcome per launch
`timescale 1ns/1ps
`default_nettype none
module tx_engine_model (
    input wire logic clk,
    input wire logic txStart,
    input wire logic [7:0] keyByte,
    input wire logic [7:0] doneDelay,
    input wire logic resultOk,
    input wire logic [1:0] resultRetries,
    input wire logic resultBusy,
    input wire logic resultNoTime,
    output logic engineDone,
    output logic engineOk,
    output logic [1:0] engineRetries,
    output logic engineChanBusy,
    output logic engineNoTime,
    output logic [3:0] keyByteIdx,
    output logic [7:0] fetchedKey [16]
);
    int i;
    // ==================================================
    // Engine sequence
    // Result lines start all ones, then show the inverse of the outcome outside the done pulse,
    // so sampling them at the wrong moment shows up as a wrong status
    initial begin
        engineDone = 1'b0;
        keyByteIdx = 4'h0;
        {engineOk, engineRetries, engineChanBusy, engineNoTime} = 5'h1f;
        forever begin
            @(posedge clk);
            if (txStart === 1'b1) begin
                // Key byte comes back one cycle after its index
                for (i = 0; i < 18; i++) begin
                    if (i < 16) keyByteIdx <= 4'(i);
                    if (i >= 2) fetchedKey[i-2] <= keyByte;
                    @(posedge clk);
                end
                repeat (doneDelay) @(posedge clk);
                engineDone <= 1'b1;
                {engineOk, engineRetries, engineChanBusy, engineNoTime} <=
                    {resultOk, resultRetries, resultBusy, resultNoTime};
                @(posedge clk);
                engineDone <= 1'b0;
                {engineOk, engineRetries, engineChanBusy, engineNoTime} <=
                    ~{resultOk, resultRetries, resultBusy, resultNoTime};
            end
        end
    end
endmodule : tx_engine_model
`default_nettype wire

// ### verification/tb_tx_frame_security_control.sv
// Self-checking bench for the transmit security control block
`timescale 1ns/1ps
`default_nettype none
module tb_tx_frame_security_control;
    import tx_sec_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [9:0] regAddr = 10'h000;
    logic regWrite = 1'b0;
    logic [7:0] regWrData = 8'h00;
    logic regRead = 1'b0;
    logic [7:0] regRdData;
    logic engineDone, engineOk, engineChanBusy, engineNoTime, txStart, txEncrypt;
    logic [1:0] engineRetries, txKeySlot;
    logic [3:0] keyByteIdx;
    buffer_t txBuffer;
    suite_t txSuite;
    logic [4:0] txTagBytes;
    logic [7:0] keyByte, snap;
    logic [7:0] doneDelay = 8'h00;
    logic resultOk = 1'b1;
    logic [1:0] resultRetries = 2'h0;
    logic resultBusy = 1'b0;
    logic resultNoTime = 1'b0;
    logic [7:0] fetchedKey [16];
    logic [4:0] snapTag;
    int errors = 0;
    int samples_checked = 0;

    tx_frame_security_control tx_frame_security_control_inst (.core_clk(core_clk),
        .reset(reset), .regAddr(regAddr), .regWrite(regWrite), .regWrData(regWrData),
        .regRead(regRead), .regRdData(regRdData), .engineDone(engineDone),
        .engineOk(engineOk), .engineRetries(engineRetries), .engineChanBusy(engineChanBusy),
        .engineNoTime(engineNoTime), .keyByteIdx(keyByteIdx), .txStart(txStart),
        .txBuffer(txBuffer), .txSuite(txSuite), .txEncrypt(txEncrypt),
        .txTagBytes(txTagBytes), .txKeySlot(txKeySlot), .keyByte(keyByte));
    tx_engine_model tx_engine_model_inst (.clk(core_clk), .txStart(txStart),
        .keyByte(keyByte), .doneDelay(doneDelay), .resultOk(resultOk),
        .resultRetries(resultRetries), .resultBusy(resultBusy), .resultNoTime(resultNoTime),
        .engineDone(engineDone), .engineOk(engineOk), .engineRetries(engineRetries),
        .engineChanBusy(engineChanBusy), .engineNoTime(engineNoTime),
        .keyByteIdx(keyByteIdx), .fetchedKey(fetchedKey));

    always #20 core_clk = ~core_clk;

    // ==================================================
    // Shared tasks
    task automatic summarize();
        if (errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string what, input logic [7:0] expv, input logic [7:0] got);
        samples_checked++;
        if (got !== expv) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, expv, got);
        end
    endtask : chk

    // Idle cycle after each access keeps strobes from being driven twice in one step
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
        @(posedge core_clk);
    endtask : wr

    task automatic rdChk(input string what, input logic [9:0] a, input logic [7:0] mask,
                         input logic [7:0] expv);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        @(posedge core_clk);
        chk(what, expv, regRdData & mask);
    endtask : rdChk

    task automatic outcome(input logic ok, input logic [1:0] rt, input logic busy,
                           input logic noTime, input logic [7:0] dly);
        resultOk <= ok;
        resultRetries <= rt;
        resultBusy <= busy;
        resultNoTime <= noTime;
        doneDelay <= dly;
    endtask : outcome

    task automatic launch(input logic [9:0] ctrl, input logic [7:0] val);
        int n;
        n = 0;
        wr(ctrl, val);
        while (txStart !== 1'b1 && n < 20) begin
            @(posedge core_clk);
            n++;
        end
        snap = {txEncrypt, txKeySlot, txBuffer, txSuite};
        snapTag = txTagBytes;
        chk("launch pulse", 8'h01, {7'h00, txStart});
        n = 0;
        while (engineDone !== 1'b1 && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        chk("engine done", 8'h01, {7'h00, engineDone});
        @(posedge core_clk);
    endtask : launch

    task automatic keyChk(input int off);
        for (int i = 0; i < 16; i++) begin
            chk("key byte", 8'(off + i) ^ 8'h5a, fetchedKey[i]);
        end
    endtask : keyChk

    function automatic logic [7:0] tagOf(input logic [2:0] c);
        case (c)
            3'h2, 3'h5: tagOf = 8'h10;
            3'h3, 3'h6: tagOf = 8'h08;
            3'h4, 3'h7: tagOf = 8'h04;
            default: tagOf = 8'h00;
        endcase
    endfunction : tagOf

    // ==================================================
    // Scenarios
    task automatic regMapCheck();
        wr(INT_ENABLES_ADDR, 8'ha5);
        rdChk("enables", INT_ENABLES_ADDR, 8'hff, 8'ha5);
        rdChk("unmapped", 10'h0ff, 8'hff, 8'h00);
        rdChk("key read", 10'h285, 8'hff, 8'h00);
        wr(SEC_CTRL_A_ADDR, 8'hff);
        rdChk("suite a", SEC_CTRL_A_ADDR, 8'hff, 8'h07);
        wr(SEC_CTRL_C_ADDR, 8'hff);
        rdChk("suite c", SEC_CTRL_C_ADDR, 8'hff, 8'h3f);
        wr(SEC_CTRL_B_ADDR, 8'hff);
        rdChk("suite b", SEC_CTRL_B_ADDR, 8'hff, 8'h70);
    endtask : regMapCheck

    task automatic suiteSweep();
        for (int j = 0; j < 48; j++) begin
            wr(KEY_BASE_ADDR + 10'(j), 8'(j) ^ 8'h5a);
        end
        for (int c = 0; c < 8; c++) begin
            outcome(1'b1, 2'h0, 1'b0, 1'b0, 8'(c * 5));
            wr(SEC_CTRL_A_ADDR, 8'(c));
            launch(NORMAL_CTRL_ADDR, 8'h03);
            chk("normal launch", {3'b100, 2'h0, 3'(c)}, snap);
            chk("tag length", tagOf(3'(c)), {3'h0, snapTag});
        end
        keyChk(0);
    endtask : suiteSweep

    task automatic keySelect();
        wr(SEC_CTRL_C_ADDR, 8'h32);
        launch(SLOT1_CTRL_ADDR, 8'h03);
        chk("slot1 launch", {3'b101, 2'h1, 3'h2}, snap);
        keyChk(16);
        launch(SLOT2_CTRL_ADDR, 8'h03);
        chk("slot2 launch", {3'b110, 2'h2, 3'h6}, snap);
        keyChk(32);
        wr(SEC_CTRL_B_ADDR, 8'h70);
        rdChk("flags clear", INT_FLAGS_ADDR, 8'h07, 8'h07);
        launch(BEACON_CTRL_ADDR, 8'h03);
        chk("beacon launch", {3'b110, 2'h3, 3'h7}, snap);
        keyChk(32);
        rdChk("beacon flags", INT_FLAGS_ADDR, 8'h07, 8'h00);
    endtask : keySelect

    task automatic resultLog();
        outcome(1'b0, 2'h3, 1'b1, 1'b0, 8'h00);
        launch(NORMAL_CTRL_ADDR, 8'h03);
        rdChk("normal fail", TX_RESULT_ADDR, 8'he1, 8'he1);
        rdChk("normal flag", INT_FLAGS_ADDR, 8'h07, 8'h01);
        rdChk("flag cleared", INT_FLAGS_ADDR, 8'h07, 8'h00);
        outcome(1'b1, 2'h1, 1'b0, 1'b0, 8'h1e);
        launch(NORMAL_CTRL_ADDR, 8'h03);
        rdChk("normal ok", TX_RESULT_ADDR, 8'he1, 8'h40);
        outcome(1'b1, 2'h2, 1'b0, 1'b0, 8'h03);
        launch(SLOT1_CTRL_ADDR, 8'h03);
        rdChk("slot1 ok", TX_RESULT_ADDR, 8'h0a, 8'h02);
        rdChk("slot1 retries", SLOT1_CTRL_ADDR, 8'hc1, 8'h80);
        outcome(1'b0, 2'h1, 1'b0, 1'b1, 8'h00);
        launch(SLOT2_CTRL_ADDR, 8'h03);
        rdChk("slot2 fail", TX_RESULT_ADDR, 8'h34, 8'h10);
        rdChk("slot2 retries", SLOT2_CTRL_ADDR, 8'hc1, 8'h40);
        rdChk("slot flags", INT_FLAGS_ADDR, 8'h07, 8'h07);
    endtask : resultLog

    task automatic plainSend();
        outcome(1'b1, 2'h0, 1'b0, 1'b0, 8'h02);
        wr(SEC_CTRL_A_ADDR, 8'h02);
        launch(NORMAL_CTRL_ADDR, 8'h01);
        chk("clear launch", {3'b000, 2'h0, 3'h0}, snap);
        rdChk("trigger gone", NORMAL_CTRL_ADDR, 8'h01, 8'h00);
    endtask : plainSend

    // ==================================================
    // Main sequence and watchdog
    initial begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        regMapCheck();
        suiteSweep();
        keySelect();
        resultLog();
        plainSend();
        summarize();
    end

    // Whole run needs under a thousand cycles; 30000 leaves ample margin
    initial begin
        #1200000;
        errors++;
        summarize();
    end
endmodule : tb_tx_frame_security_control
`default_nettype wire
